/* hdl/lnbc_pkg.sv */
// Purpose: Shared constants and types for the supply controller serial target
// Assumes: 7-bit target addressing, 8-bit system registers
// Notes:   Register select lives in the top three bits of each written byte
package lnbc_pkg;
  localparam logic [4:0] LNBC_ADDR_BASE  = 5'h02;
  localparam logic [2:0] LNBC_SEL_DIAG   = 3'h0;
  localparam logic [2:0] LNBC_SEL_TONE   = 3'h1;
  localparam logic [2:0] LNBC_SEL_LIMIT  = 3'h2;
  localparam logic [2:0] LNBC_SEL_OUTPUT = 3'h3;
  localparam logic [7:0] LNBC_REG_RESET  = 8'h00;
  localparam int         LNBC_SEL_MSB    = 7;
  localparam int         LNBC_SEL_LSB    = 5;
  localparam logic [7:0] LNBC_DIAG_RO    = 8'h1f;
  localparam logic [3:0] LNBC_LAST_BIT   = 4'h7;
  localparam logic [3:0] LNBC_ACK_BIT    = 4'h8;

  typedef enum logic [2:0] {
    LNBC_IDLE,
    LNBC_ADDR,
    LNBC_WRITE,
    LNBC_READ,
    LNBC_WAIT
  } lnbc_state_e;

  typedef struct packed {
    logic [7:0] diag;
    logic [7:0] tone;
    logic [7:0] limit;
    logic [7:0] outp;
  } lnbc_regs_s;
endpackage

/* hdl/lnbc_sync.sv */
// Purpose: Two-stage synchroniser for a bundle of pin levels
// Assumes: Inputs are asynchronous levels
// Notes:   Only the second stage leaves this module
`timescale 1ns/10ps
`default_nettype none
module lnbc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // System clock
  input  wire logic         rst_n,  // Async reset, active low
  input  wire logic [W-1:0] d,      // Async levels
  output logic      [W-1:0] q       // Synchronised levels
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule
`default_nettype wire

/* hdl/lnbc_i2c_target.sv */
// Purpose: Serial target port with power-good gating and strap addressing
// Assumes: Bus clock far slower than clk; pins sampled through synchronisers
// Notes:   Reads return all four system registers in turn, starting at diag
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1 - A read begins when our address arrives with the direction bit set.
// R2 - In read mode each bus clock carries one data bit, most significant first.
// R3 - An acknowledge on the ninth clock makes the device send another byte.
// R4 - No acknowledge on the ninth clock ends the read and stops data output.
// R5 - Read data copies the system registers, with live fault bits in diag.
// R6 - The interface resets at power-on and ignores the bus while power is bad.
// R7 - All four system registers are held at zero while power is bad.
// R8 - Once power is good the interface runs and accepts register writes.
// R9 - The supply enable bit starts cleared and the master sets it last.
// R10 - The target address is 0001000 with the two straps replacing its low bits.
// R11 - The address byte low bit picks read when one and write when zero.
// R12 - Writes reach only the tone, limit and output registers, never diag.
// R13 - After a read not-acknowledge the device waits for a stop or start.
module lnbc_i2c_target
  import lnbc_pkg::*;
(
  input  wire logic       clk,               // 250 MHz system clock
  input  wire logic       rst_n,             // Async reset, active low
  input  wire logic       scl_i,             // Bus clock pin level
  input  wire logic       sda_i,             // Bus data pin level
  output logic            sda_o,             // Bus data drive value
  output logic            sda_oe,            // Bus data drive enable
  input  wire logic       power_ok,          // Supply good from undervoltage_lockout
  input  wire logic       addr_strap_low,    // Address strap, bit 0
  input  wire logic       addr_strap_high,   // Address strap, bit 1
  input  wire logic [4:0] diag_flags,        // Live fault and diagnostic flags
  output lnbc_regs_s      sys_regs           // System register contents
);
  logic       rst_meta_ff, rst_sync_ff;
  logic [4:0] pins;
  logic       scl_s, sda_s, pwr_s, strap_l, strap_h;
  logic       scl_d_ff, sda_d_ff;
  logic       scl_rise, scl_fall, start_c, stop_c;
  lnbc_state_e state_ff;
  logic [3:0] bit_ff;
  logic [7:0] shift_ff;
  logic [1:0] rd_sel_ff;
  logic       sda_o_ff, sda_oe_ff;
  lnbc_regs_s regs_ff;
  logic [7:0] rd_byte;

  // ====================================================================
  // Reset release and pin synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  lnbc_sync #(.W(5)) u_sync (
    .clk   (clk),
    .rst_n (rst_sync_ff),
    .d     ({~scl_i, ~sda_i, power_ok, addr_strap_low, addr_strap_high}),
    .q     (pins)
  );
  // Bus pins pass inverted so the zero reset of the synchroniser reads as idle high;
  // otherwise the first cycles after reset would look like a bus clock edge
  assign {scl_s, sda_s, pwr_s, strap_l, strap_h} = pins ^ 5'h18;

  // ====================================================================
  // Bus condition detection
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // Register picked by the current read position
  always_comb begin
    unique case (rd_sel_ff)
      2'd0:    rd_byte = regs_ff.diag;  // R5
      2'd1:    rd_byte = regs_ff.tone;
      2'd2:    rd_byte = regs_ff.limit;
      default: rd_byte = regs_ff.outp;
    endcase
  end

  // ====================================================================
  // Transfer sequencing
  // Bit counter counts rising edges: 0..7 data, 8 acknowledge slot
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff  <= LNBC_IDLE;
      bit_ff    <= 4'h0;
      shift_ff  <= 8'h00;
      rd_sel_ff <= 2'd0;
    end else if (!pwr_s) begin
      state_ff  <= LNBC_IDLE;  // R6
      bit_ff    <= 4'h0;
      shift_ff  <= 8'h00;
      rd_sel_ff <= 2'd0;
    end else if (start_c) begin
      state_ff <= LNBC_ADDR;  // R13
      bit_ff   <= 4'h0;
    end else if (stop_c) begin
      state_ff <= LNBC_IDLE;  // R13
    end else if (scl_rise) begin
      if (bit_ff == LNBC_ACK_BIT) begin
        bit_ff <= 4'h0;
        unique case (state_ff)
          LNBC_ADDR: begin
            if (shift_ff[7:1] == {LNBC_ADDR_BASE, strap_h, strap_l}) begin  // R10
              state_ff  <= shift_ff[0] ? LNBC_READ : LNBC_WRITE;  // R1 R11
              rd_sel_ff <= 2'd0;
            end else begin
              state_ff <= LNBC_WAIT;
            end
          end
          LNBC_READ: begin
            if (sda_s) begin
              state_ff <= LNBC_WAIT;  // R4 R13
            end else begin
              rd_sel_ff <= rd_sel_ff + 2'd1;  // R3
            end
          end
          default: ;
        endcase
      end else begin
        bit_ff   <= bit_ff + 4'h1;
        shift_ff <= {shift_ff[6:0], sda_s};
      end
    end
  end

  // ====================================================================
  // Data line drive, set only on a bus clock fall; released at once on start, stop or power bad
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      sda_o_ff  <= 1'b1;
      sda_oe_ff <= 1'b0;
    end else if (!pwr_s || start_c || stop_c) begin
      sda_o_ff  <= 1'b1;  // R6
      sda_oe_ff <= 1'b0;
    end else if (scl_fall) begin
      sda_o_ff  <= 1'b1;
      sda_oe_ff <= 1'b0;
      if (bit_ff == LNBC_ACK_BIT) begin
        // Acknowledge slot: our address or a write byte; in a read it is the master's
        if (state_ff == LNBC_WRITE ||
            (state_ff == LNBC_ADDR &&
             shift_ff[7:1] == {LNBC_ADDR_BASE, strap_h, strap_l})) begin  // R10
          sda_o_ff  <= 1'b0;
          sda_oe_ff <= 1'b1;
        end
      end else if (state_ff == LNBC_READ) begin
        // Count 0 is the fall after the acknowledge, which carries the msb
        sda_o_ff  <= rd_byte[LNBC_LAST_BIT[2:0] - bit_ff[2:0]];  // R2
        sda_oe_ff <= 1'b1;
      end
    end
  end

  // ====================================================================
  // System registers
  // Selector field of a write byte picks the register; diag is read-only
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      regs_ff <= '0;
    end else if (!pwr_s) begin
      regs_ff <= '0;  // R7 R9
    end else begin
      regs_ff.diag[4:0] <= diag_flags & LNBC_DIAG_RO[4:0];  // R5
      if (scl_rise && bit_ff == LNBC_LAST_BIT && state_ff == LNBC_WRITE) begin  // R8
        unique case (shift_ff[6:4])
          LNBC_SEL_TONE:   regs_ff.tone  <= {shift_ff[6:0], sda_s};  // R12
          LNBC_SEL_LIMIT:  regs_ff.limit <= {shift_ff[6:0], sda_s};
          LNBC_SEL_OUTPUT: regs_ff.outp  <= {shift_ff[6:0], sda_s};
          default: ;
        endcase
      end
    end
  end

  assign sda_o    = sda_o_ff;
  assign sda_oe   = sda_oe_ff;
  assign sys_regs = regs_ff;

  // ====================================================================
  // Checks
  quiet_unpowered_a: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    !pwr_s |=> !sda_oe_ff) else $error("Data driven while power bad");  // R6
  regs_cleared_a: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    !pwr_s |=> regs_ff == '0) else $error("Registers not zero while power bad");  // R7
  nack_ends_read_a: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (state_ff == LNBC_READ && scl_rise && bit_ff == LNBC_ACK_BIT && sda_s && pwr_s
     && !start_c && !stop_c) |=> state_ff == LNBC_WAIT) else $error("Read kept after nack");  // R4
  wait_silent_a: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (state_ff == LNBC_WAIT && !sda_oe_ff) |=> !sda_oe_ff) else $error("Drive while waiting");  // R13
  diag_write_a: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (pwr_s && $past(pwr_s)) |-> regs_ff.diag[7:5] == 3'h0) else $error("Diag written");  // R12
  ack_advance_a: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (state_ff == LNBC_READ && scl_rise && bit_ff == LNBC_ACK_BIT && !sda_s && pwr_s
     && !start_c && !stop_c) |=> rd_sel_ff == $past(rd_sel_ff) + 2'd1)
    else $error("No next byte after ack");  // R3
  addr_match_a: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (state_ff == LNBC_ADDR && scl_rise && bit_ff == LNBC_ACK_BIT && pwr_s && !start_c
     && !stop_c && shift_ff == {LNBC_ADDR_BASE, strap_h, strap_l, 1'b1})
    |=> state_ff == LNBC_READ) else $error("Read not entered");  // R1
  msb_first_a: assert property (@(posedge clk) disable iff (!rst_sync_ff)  // R2
    (state_ff == LNBC_READ && scl_fall && bit_ff == 4'h0 && pwr_s && !start_c
     && !stop_c) |=> sda_oe_ff && sda_o_ff == $past(rd_byte[7]))
    else $error("First bit not msb");
  addr_ack_a: assert property (@(posedge clk) disable iff (!rst_sync_ff)  // R10
    (state_ff == LNBC_ADDR && scl_fall && bit_ff == LNBC_ACK_BIT && pwr_s && !start_c
     && !stop_c && shift_ff[7:1] == {LNBC_ADDR_BASE, strap_h, strap_l})
    |=> sda_oe_ff && !sda_o_ff) else $error("Address not acknowledged");
  read_release_a: assert property (@(posedge clk) disable iff (!rst_sync_ff)  // R4
    (state_ff == LNBC_READ && scl_fall && bit_ff == LNBC_ACK_BIT && pwr_s && !start_c
     && !stop_c) |=> !sda_oe_ff) else $error("Data driven in master ack slot");
endmodule
`default_nettype wire

/* verif/lnbc_master.sv */
// Purpose: Behavioural bus master facing the supply controller target
// Assumes: Open-drain data wire with pull-up, resolved in the bench
// Notes:   Clock stands high between frames; every phase lasts 8 clk
`timescale 1ns/10ps
`default_nettype none
module lnbc_master (
  input  wire logic clk,    // System clock
  input  wire logic sda,    // Resolved data wire
  output logic      scl,    // Bus clock drive
  output logic      sda_m   // Data drive, high releases
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // ==========================
  // Bus phases
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Also serves as repeated start
  task automatic start();
    sda_m = 1'b1;
    tick(8);
    scl = 1'b1;
    tick(8);
    sda_m = 1'b0;
    tick(8);
    scl = 1'b0;
    tick(8);
  endtask
  task automatic stop();
    sda_m = 1'b0;
    tick(8);
    scl = 1'b1;
    tick(8);
    sda_m = 1'b1;
    tick(8);
  endtask
  // Nine bits, MSB first; data changes only while the clock is low
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      sda_m = o[k];
      tick(8);
      scl = 1'b1;
      tick(4);
      i[k] = sda;
      tick(4);
      scl = 1'b0;
      tick(8);
    end
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] q);
    logic [8:0] r;
    xfer({8'hff, last}, r);
    q = r[8:1];
  endtask
endmodule
`default_nettype wire

/* verif/lnbc_i2c_target_tb.sv */
// Purpose: Self-checking bench for the supply controller serial target
// Assumes: Master model drives the bus; data wire pulled high
// Notes:   Each scenario is one task that judges its own results
`timescale 1ns/10ps
`default_nettype none
module lnbc_i2c_target_tb;
  import lnbc_pkg::*;
  localparam logic [6:0] addr0 = 7'h08;
  logic       clk, rst_n, power_ok, strap_l, strap_h, sda_o, sda_oe, scl, sda_m;
  logic [4:0] flags;
  lnbc_regs_s regs;
  int         n_errors = 0;
  int         comparisons = 0;
  wire logic  sda = sda_m & (sda_oe ? sda_o : 1'b1);
  lnbc_i2c_target uut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .power_ok(power_ok), .addr_strap_low(strap_l),
    .addr_strap_high(strap_h), .diag_flags(flags), .sys_regs(regs));
  lnbc_master m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  always #2 clk = ~clk;
  // ==========================
  // Checking and bus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, output logic [1:0] acks);
    logic [8:0] r;
    m.start();
    m.xfer({a, 1'b0, 1'b1}, r);
    acks[1] = r[0];
    m.xfer({d, 1'b1}, r);
    acks[0] = r[0];
    m.stop();
  endtask
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================
  // Scenarios
  task automatic t_strap();
    logic [1:0] a;
    for (int i = 0; i < 4; i++) begin
      strap_h = i[1];
      strap_l = i[0];
      m.tick(8);
      wr(addr0 | 7'(i), 8'h20 | 8'(i), a);
      chk(a, 2'b00);
      chk(regs.tone, 8'h20 | 8'(i));
      wr(addr0 | 7'(i ^ 1), 8'h3f, a);
      chk(a, 2'b11);
      chk(regs.tone, 8'h20 | 8'(i));
    end
    {strap_h, strap_l} = 2'b00;
    m.tick(8);
    $display("test strap done");
  endtask
  task automatic t_read();
    logic [1:0] a;
    logic [8:0] r;
    logic [7:0] q;
    logic [7:0] e [5];
    wr(addr0, 8'h35, a);
    wr(addr0, 8'h4a, a);
    wr(addr0, 8'h1f, a);
    chk(a, 2'b00);
    wr(addr0, 8'h70, a);
    flags = 5'h15;
    m.tick(8);
    chk(regs, {8'h15, 8'h35, 8'h4a, 8'h70});
    e = '{8'h15, 8'h35, 8'h4a, 8'h70, 8'h15};
    m.start();
    m.xfer({addr0, 1'b1, 1'b1}, r);
    chk(r[0], 1'b0);
    for (int k = 0; k < 5; k++) begin
      m.rd_byte(k == 4, q);
      chk(q, e[k]);
    end
    m.xfer(9'h1ff, r);
    chk(r, 9'h1ff);
    m.stop();
    $display("test read done");
  endtask
  task automatic t_power();
    logic [1:0] a;
    power_ok = 1'b0;
    m.tick(8);
    chk(regs, 32'h0);
    wr(addr0, 8'h35, a);
    chk(a, 2'b11);
    chk(regs, 32'h0);
    power_ok = 1'b1;
    m.tick(8);
    chk(regs.outp[4], 1'b0);
    wr(addr0, 8'h6a, a);
    chk(a, 2'b00);
    chk(regs.outp, 8'h6a);
    $display("test power done");
  endtask
  // ==========================
  // Main sequence and watchdog
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    power_ok = 1'b1;
    strap_l = 1'b0;
    strap_h = 1'b0;
    flags = 5'h0a;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    m.tick(10);
    chk(regs, {8'h0a, 24'h0});
    t_strap();
    t_read();
    t_power();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
